// File: rtl/prsu_core.v
// Program counter, return stack and fast shadow unit of the core
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "prsu_defines.vh"
`default_nettype none

module prsu_core (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Decoder and interrupt controller requests
  input  wire        op_valid,
  input  wire [3:0]  op_code,
  input  wire        op_fast,
  input  wire [20:0] op_target,
  input  wire        stack_fault_reset_enable,
  // Live core registers for the shadow copy
  input  wire [7:0]  status_in,
  input  wire [7:0]  working_register_in,
  input  wire [7:0]  bank_select_register_in,
  // Program memory fetch
  input  wire [15:0] fetch_word,
  // Outputs to the core
  output reg  [20:0] program_counter,
  output reg  [3:0]  phase,
  output reg  [15:0] instr_reg,
  output reg         exec_valid,
  output reg         device_reset_req,
  output reg         restore_strobe,
  output reg  [7:0]  restore_status,
  output reg  [7:0]  restore_working,
  output reg  [7:0]  restore_bank
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg        rst_meta;       // First synchroniser stage
  reg        rst_n;          // Released reset used by the design

  // Reset asserts at once, releases after two edges
  // Keeps the release of rst_b clear of the clock edge for all state
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [20:0] stack_mem [1:`PRSU_DEPTH]; // Entry 0 has no storage
  reg [4:0]  stack_depth_field;         // Pointer
  reg        stack_full_flag;           // Sticky full
  reg        stack_underflow_flag;      // Sticky underflow
  reg [7:0]  counter_high_latch;        // Staging for counter bits 15:8
  reg [4:0]  counter_upper_latch;       // Staging for counter bits 20:16
  reg [7:0]  shadow_status;             // Fast shadow copies
  reg [7:0]  shadow_working;
  reg [7:0]  shadow_bank;
  reg        flush_next;                // Drop the prefetched word
  reg        hw_ptr_cycle;              // Pointer moved by hardware this cycle

  // ---------------------------------------------------------------
  // Decode of the request and the bus
  // ---------------------------------------------------------------
  // Requests outside the Q3 edge are ignored altogether
  wire       op_take   = op_valid & phase[2];         // Executed in Q3
  wire       is_call   = (op_code == `PRSU_OP_CALL) |
                         (op_code == `PRSU_OP_REL_CALL);
  wire       is_int    = (op_code == `PRSU_OP_INT_ACK);
  wire       is_ret    = (op_code == `PRSU_OP_RETURN) |
                         (op_code == `PRSU_OP_RET_LIT) |
                         (op_code == `PRSU_OP_INT_RET);
  wire       is_push   = op_take & (is_call | is_int |
                         (op_code == `PRSU_OP_PUSH));
  wire       is_pop    = op_take & (is_ret | (op_code == `PRSU_OP_POP));
  wire       is_jump   = op_take & (op_code == `PRSU_OP_JUMP);
  wire       pc_change = op_take & (is_call | is_int | is_ret |
                         (op_code == `PRSU_OP_JUMP));

  // Bus phases; a register only changes at the end of an access phase
  wire       bus_setup = psel & ~penable;
  wire       bus_acc   = psel & penable & pready;
  wire       bus_wr    = bus_acc & pwrite & ~pslverr;
  wire       bus_rd    = bus_acc & ~pwrite & ~pslverr;
  wire       wr_sp     = bus_wr & (paddr == `PRSU_OFS_STACK_PTR);
  wire       wr_low    = bus_wr & (paddr == `PRSU_OFS_CNT_LOW);
  wire       rd_low    = bus_rd & (paddr == `PRSU_OFS_CNT_LOW);
  wire       wr_top    = bus_wr & ((paddr == `PRSU_OFS_TOP_UPPER) |
                         (paddr == `PRSU_OFS_TOP_HIGH) |
                         (paddr == `PRSU_OFS_TOP_LOW));

  // Entry under the pointer, zero when the stack is empty
  wire [20:0] top_entry = (stack_depth_field == `PRSU_SP_RESET) ?
                          `PRSU_PC_RESET : stack_mem[stack_depth_field];
  wire        sp_at_top = (stack_depth_field == `PRSU_SP_TOP);
  wire [4:0]  sp_inc    = stack_depth_field + 5'h01;
  wire [4:0]  sp_dec    = stack_depth_field - 5'h01;
  // Push that reaches the last entry, and pop from empty
  wire        push_last = is_push & (sp_inc == `PRSU_SP_TOP);
  wire        pop_empty = is_pop & (stack_depth_field == `PRSU_SP_RESET);
  wire        fault_rst = stack_fault_reset_enable &
                          (push_last | pop_empty);

  // ---------------------------------------------------------------
  // Quarter phase generator
  // ---------------------------------------------------------------
  // Rotating one-hot Q1..Q4, one core clock each
  // Reset parks in Q4 so the first released edge opens Q1
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `PRSU_Q4;
    end else begin
      case (phase)
        `PRSU_Q1: phase <= `PRSU_Q2;
        `PRSU_Q2: phase <= `PRSU_Q3;
        `PRSU_Q3: phase <= `PRSU_Q4;
        `PRSU_Q4: phase <= `PRSU_Q1;
        default:  phase <= `PRSU_Q1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Fetch pipeline
  // ---------------------------------------------------------------
  // Word latched in Q4, executed during the next cycle
  // flush_next carries a counter change from the Q3 edge to the next Q4
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg  <= 16'h0000;
      exec_valid <= 1'b0;
      flush_next <= 1'b0;
    end else begin
      if (pc_change | fault_rst) begin
        flush_next <= 1'b1;               // Prefetch is stale
      end
      if (phase[3]) begin
        instr_reg  <= fetch_word;
        // A flushed slot executes as a no-op
        exec_valid <= ~(flush_next | pc_change | fault_rst);
        flush_next <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter and latches
  // ---------------------------------------------------------------
  // Stack op outranks software write, which outranks the step
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter     <= `PRSU_PC_RESET;
      counter_high_latch  <= 8'h00;
      counter_upper_latch <= 5'h00;
    end else begin
      if (fault_rst) begin
        program_counter <= `PRSU_PC_RESET;        // Restart at vector zero
      end else if (pop_empty) begin
        program_counter <= `PRSU_PC_RESET;
      end else if (is_pop & is_ret) begin
        program_counter <= top_entry;
      end else if (op_take & (is_call | is_int | is_jump)) begin
        program_counter <= {op_target[20:1], 1'b0};
      end else if (wr_low) begin
        // Low byte write pulls both latches in
        program_counter <= {counter_upper_latch, counter_high_latch,
                            pwdata[7:1], 1'b0};
      end else if (phase[0]) begin
        program_counter <= program_counter + `PRSU_PC_STEP;
      end
      // Latch registers: software writes, or low byte read copies
      if (rd_low) begin
        counter_high_latch  <= program_counter[15:8];
        counter_upper_latch <= program_counter[20:16];
      end else if (bus_wr & (paddr == `PRSU_OFS_HIGH_LATCH)) begin
        counter_high_latch  <= pwdata[7:0];
      end else if (bus_wr & (paddr == `PRSU_OFS_UPPER_LATCH)) begin
        counter_upper_latch <= pwdata[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Stack pointer and flags
  // ---------------------------------------------------------------
  // Pointer moves on hardware ops; flags are set-wins sticky
  // hw_ptr_cycle guards the rest of the instruction cycle from software
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_depth_field    <= `PRSU_SP_RESET;
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
      device_reset_req     <= 1'b0;
      hw_ptr_cycle         <= 1'b0;
    end else begin
      device_reset_req <= fault_rst;
      if (phase[3]) begin
        hw_ptr_cycle <= 1'b0;
      end else if (is_push | is_pop) begin
        hw_ptr_cycle <= 1'b1;
      end
      // Pointer
      if (fault_rst) begin
        stack_depth_field <= `PRSU_SP_RESET;
      end else if (is_push) begin
        if (!sp_at_top) begin
          stack_depth_field <= sp_inc;
        end
      end else if (is_pop) begin
        if (!pop_empty) begin
          stack_depth_field <= sp_dec;
        end
      end else if (wr_sp & ~hw_ptr_cycle) begin
        stack_depth_field <= pwdata[4:0];
      end
      // A same-edge set beats a software clear so no event is lost
      // Full flag: software may only clear it
      if (push_last) begin
        stack_full_flag <= 1'b1;
      end else if (wr_sp & ~pwdata[`PRSU_SP_FULL_BIT]) begin
        stack_full_flag <= 1'b0;
      end
      // Underflow flag: software may only clear it
      if (pop_empty) begin
        stack_underflow_flag <= 1'b1;
      end else if (wr_sp & ~pwdata[`PRSU_SP_UNF_BIT]) begin
        stack_underflow_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stack storage
  // ---------------------------------------------------------------
  // Push writes the new top; a stuck push at 31 writes nothing
  // Entry 0 is never written; pointer zero only marks an empty stack
  always @(posedge core_clk) begin
    if (is_push & ~sp_at_top) begin
      if (push_last & stack_fault_reset_enable) begin
        stack_mem[sp_inc] <= program_counter + `PRSU_PC_STEP;
      end else begin
        stack_mem[sp_inc] <= program_counter;
      end
    end else if (wr_top & (stack_depth_field != `PRSU_SP_RESET)) begin
      // Software replaces one byte of the top entry
      case (paddr)
        `PRSU_OFS_TOP_UPPER:
          stack_mem[stack_depth_field] <= {pwdata[4:0], top_entry[15:0]};
        `PRSU_OFS_TOP_HIGH:
          stack_mem[stack_depth_field] <= {top_entry[20:16], pwdata[7:0],
                                           top_entry[7:0]};
        default:
          stack_mem[stack_depth_field] <= {top_entry[20:8], pwdata[7:0]};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Fast shadow copy
  // ---------------------------------------------------------------
  // Loaded on vectoring or fast call, returned on fast return
  // Software has no path to the shadow; it is neither read nor written
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_status   <= 8'h00;
      shadow_working  <= 8'h00;
      shadow_bank     <= 8'h00;
      restore_strobe  <= 1'b0;
      restore_status  <= 8'h00;
      restore_working <= 8'h00;
      restore_bank    <= 8'h00;
    end else begin
      restore_strobe <= 1'b0;
      if (op_take & (is_int | (is_call & op_fast))) begin
        shadow_status  <= status_in;
        shadow_working <= working_register_in;
        shadow_bank    <= bank_select_register_in;
      end
      if (op_take & op_fast & ((op_code == `PRSU_OP_RETURN) |
                               (op_code == `PRSU_OP_INT_RET))) begin
        restore_strobe  <= 1'b1;
        restore_status  <= shadow_status;
        restore_working <= shadow_working;
        restore_bank    <= shadow_bank;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  reg [31:0] next_rdata;   // Read value for the addressed register
  reg        next_err;     // Unmapped address

  // Read multiplexer; unused upper bits read as zero
  // Unmapped offsets answer with an error and read as zero
  always @* begin
    next_err   = 1'b0;
    next_rdata = 32'h00000000;
    case (paddr)
      `PRSU_OFS_STACK_PTR:
        next_rdata = {24'h000000, stack_full_flag, stack_underflow_flag,
                      1'b0, stack_depth_field};
      `PRSU_OFS_TOP_UPPER:   next_rdata = {27'h0000000, top_entry[20:16]};
      `PRSU_OFS_TOP_HIGH:    next_rdata = {24'h000000, top_entry[15:8]};
      `PRSU_OFS_TOP_LOW:     next_rdata = {24'h000000, top_entry[7:0]};
      `PRSU_OFS_CNT_LOW:     next_rdata = {24'h000000, program_counter[7:0]};
      `PRSU_OFS_HIGH_LATCH:  next_rdata = {24'h000000, counter_high_latch};
      `PRSU_OFS_UPPER_LATCH: next_rdata = {27'h0000000, counter_upper_latch};
      `PRSU_OFS_PC_VIEW:     next_rdata = {11'h000, program_counter};
      default:               next_err   = 1'b1;
    endcase
  end

  // One wait-free access phase; data and error captured in setup
  // pslverr drops at the end of the access so it never stands in idle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= bus_setup;
      if (bus_setup) begin
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err | (pwrite & (paddr == `PRSU_OFS_PC_VIEW));
      end else if (bus_acc) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // prsu_core

`default_nettype wire

// File: rtl/prsu_defines.vh
// Constants for the program counter and return stack unit
`ifndef PRSU_DEFINES_VH
`define PRSU_DEFINES_VH
// ---------------------------------------------------------------
// Register byte offsets on the APB
// ---------------------------------------------------------------
`define PRSU_OFS_STACK_PTR    12'h000
`define PRSU_OFS_TOP_UPPER    12'h004
`define PRSU_OFS_TOP_HIGH     12'h008
`define PRSU_OFS_TOP_LOW      12'h00C
`define PRSU_OFS_CNT_LOW      12'h010
`define PRSU_OFS_HIGH_LATCH   12'h014
`define PRSU_OFS_UPPER_LATCH  12'h018
`define PRSU_OFS_PC_VIEW      12'h01C
// ---------------------------------------------------------------
// Stack pointer register layout
// ---------------------------------------------------------------
`define PRSU_SP_FULL_BIT      7
`define PRSU_SP_UNF_BIT       6
`define PRSU_SP_MSB           4
`define PRSU_SP_RESET         5'h00
`define PRSU_SP_TOP           5'h1F
// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define PRSU_PC_W             21
`define PRSU_DEPTH            31
`define PRSU_PC_RESET         21'h000000
`define PRSU_PC_STEP          21'h000002
// ---------------------------------------------------------------
// Decoder operation codes
// ---------------------------------------------------------------
`define PRSU_OP_NONE          4'h0
`define PRSU_OP_CALL          4'h1
`define PRSU_OP_REL_CALL      4'h2
`define PRSU_OP_INT_ACK       4'h3
`define PRSU_OP_RETURN        4'h4
`define PRSU_OP_RET_LIT       4'h5
`define PRSU_OP_INT_RET       4'h6
`define PRSU_OP_PUSH          4'h7
`define PRSU_OP_POP           4'h8
`define PRSU_OP_JUMP          4'h9
// ---------------------------------------------------------------
// Quarter phases, one-hot
// ---------------------------------------------------------------
`define PRSU_Q1               4'h1
`define PRSU_Q2               4'h2
`define PRSU_Q3               4'h4
`define PRSU_Q4               4'h8
`endif

// File: tb/prsu_asserts.sv
// Concurrent checks on the ports of the program counter and return stack unit
`timescale 1ns/1ps
`default_nettype none
module prsu_asserts (
  // Clock, reset and APB
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Decoder requests
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic        op_fast,
  input wire logic [20:0] op_target,
  input wire logic        stack_fault_reset_enable,
  // Core outputs
  input wire logic [20:0] program_counter,
  input wire logic [3:0]  phase,
  input wire logic        exec_valid,
  input wire logic        device_reset_req,
  input wire logic        restore_strobe
);
  logic [1:0] rcnt;     // Edges since reset release, saturating
  logic       settled;  // Two-flop release is over
  logic       low_wr;   // Counter low byte written at this edge
  logic       fault_op; // Any request taken in Q3 with fault reset on
  logic       fast_ret; // Fast return or fast interrupt return taken
  // Wait out the internal release before judging all but the error and cause checks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt <= 2'h0;
    end else if (rcnt != 2'h3) begin
      rcnt <= rcnt + 2'h1;
    end
  end
  assign settled  = (rcnt == 2'h3);
  assign low_wr   = psel && penable && pwrite && (paddr == 12'h010);
  assign fault_op = (phase == 4'h4) && op_valid && stack_fault_reset_enable;
  assign fast_ret = (phase == 4'h4) && op_valid && op_fast && (op_code inside {4'h4, 4'h6});
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Direct loads of the counter: calls, interrupt, jump
  sequence s_load;
    settled && phase == 4'h4 && op_valid && !stack_fault_reset_enable &&
      (op_code inside {4'h1, 4'h2, 4'h3, 4'h9});
  endsequence
  // Fast return accepted
  sequence s_fast_ret;
    settled && fast_ret;
  endsequence
  AST_PHASE_WRAP: assert property (settled && phase == 4'h8 |=> phase == 4'h1)
    else $error("phase did not wrap to Q1");
  AST_PHASE_STEP: assert property (settled && phase != 4'h8 |=> phase == {$past(phase[2:0]), 1'b0})
    else $error("phase did not advance");
  AST_PC_STEP: assert property (settled && phase == 4'h1 && !low_wr |=>
    program_counter == $past(program_counter) + 21'h000002)
    else $error("counter did not step by two in Q1");
  AST_PC_HOLD: assert property (settled && phase == 4'h2 && !low_wr |=> $stable(program_counter))
    else $error("counter moved outside Q1");
  AST_PC_EVEN: assert property (settled |-> !program_counter[0])
    else $error("counter bit zero set");
  AST_LOAD_DIRECT: assert property (s_load |=> program_counter == {$past(op_target[20:1]), 1'b0})
    else $error("counter not loaded from target");
  AST_FLUSH: assert property (s_load |-> ##2 !exec_valid)
    else $error("prefetched word not flushed");
  AST_PREADY: assert property (settled |-> pready == $past(psel && !penable))
    else $error("ready not in access phase");
  AST_ERR_ACCESS: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access phase");
  AST_RESET_CAUSE: assert property (device_reset_req |-> $past(fault_op) && !$past(device_reset_req))
    else $error("device reset without fault");
  AST_RESTORE: assert property (s_fast_ret |-> ##1 restore_strobe ##1 !restore_strobe)
    else $error("fast restore pulse wrong");
  AST_RESTORE_CAUSE: assert property (restore_strobe |-> $past(fast_ret))
    else $error("restore without fast return");
endmodule // prsu_asserts
`default_nettype wire

// File: tb/prsu_dec_model.sv
// Behavioural decoder and interrupt controller issuing stack operations
`timescale 1ns/1ps
`default_nettype none
module prsu_dec_model (
  // Clock from the bench, phase from the unit
  input  wire logic        core_clk,
  input  wire logic [3:0]  phase,
  // Requests to the unit
  output var  logic        op_valid,
  output var  logic [3:0]  op_code,
  output var  logic        op_fast,
  output var  logic [20:0] op_target
);
  // Idle at time zero
  initial begin
    op_valid  = 1'b0;
    op_code   = 4'h0;
    op_fast   = 1'b0;
    op_target = 21'h000000;
  end
  // One request per instruction cycle, raised for the Q3 slot only
  task automatic issue(input logic [3:0] code, input logic fast, input logic [20:0] tgt);
    int n;
    n = 0;
    @(posedge core_clk);
    while (phase !== 4'h2 && n < 16) begin
      @(posedge core_clk);
      n++;
    end
    if (n < 16) begin
      op_valid  <= 1'b1;
      op_code   <= code;
      op_fast   <= fast;
      op_target <= tgt;
      @(posedge core_clk);
      // Released fields show the inverse so stale values are not reused
      op_valid  <= 1'b0;
      op_code   <= ~code;
      op_fast   <= ~fast;
      op_target <= ~tgt;
    end else begin
      testbench.bad_count++;
      testbench.close_out();
    end
  endtask
endmodule // prsu_dec_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the program counter and return stack unit
`timescale 1ns/1ps
`include "prsu_defines.vh"
`default_nettype none
module testbench;
  logic        core_clk, rst_b, psel, penable, pwrite, fault_en, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, op_valid, op_fast, exec_valid, dev_rst, rs;
  logic [3:0]  op_code, phase;
  logic [20:0] op_target, pc;
  logic [7:0]  st_in, wk_in, bk_in, r_st, r_wk, r_bk;
  logic [15:0] fw = 16'h0000, ir;
  int          bad_count, checked, i;
  // ---------------------------------------------------------------
  // Unit, decoder model, clock
  // ---------------------------------------------------------------
  prsu_core uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_fast(op_fast),
    .op_target(op_target), .stack_fault_reset_enable(fault_en), .status_in(st_in),
    .working_register_in(wk_in), .bank_select_register_in(bk_in), .fetch_word(fw),
    .program_counter(pc), .phase(phase), .instr_reg(ir), .exec_valid(exec_valid),
    .device_reset_req(dev_rst), .restore_strobe(rs), .restore_status(r_st),
    .restore_working(r_wk), .restore_bank(r_bk));
  prsu_dec_model dec (.core_clk(core_clk), .phase(phase), .op_valid(op_valid),
    .op_code(op_code), .op_fast(op_fast), .op_target(op_target));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Program memory words keep changing
  always @(posedge core_clk) fw <= fw + 16'h1111;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    if (n >= 16) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 32'h00000000);
    cmp(nm, {24'h000000, e}, rv);
  endtask
  task automatic chk_pc(input logic [20:0] e);
    #1 cmp("program_counter", {11'h000, e}, {11'h000, pc});
  endtask
  task automatic shadow(input logic [7:0] s, input logic [7:0] w, input logic [7:0] b);
    @(posedge core_clk);
    st_in <= s;
    wk_in <= w;
    bk_in <= b;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, fault_en, bad_count, checked} = '0;
    {paddr, pwdata, st_in, wk_in, bk_in} = '0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`PRSU_OFS_STACK_PTR, 8'h00, "ptr_reset");
    apb(1'b0, 12'h020, 32'h00000000);
    cmp("unmapped_err", 32'h1, {31'h0, ev});
    apb(1'b1, `PRSU_OFS_PC_VIEW, 32'h00000000);
    cmp("view_wr_err", 32'h1, {31'h0, ev});
    $display("test registers done");
    apb(1'b1, `PRSU_OFS_HIGH_LATCH, 32'h00000012);
    apb(1'b1, `PRSU_OFS_UPPER_LATCH, 32'h00000005);
    apb(1'b1, `PRSU_OFS_CNT_LOW, 32'h00000035);
    chk_pc(21'h051234);
    shadow(8'hA1, 8'hB2, 8'hC3);
    dec.issue(4'h9, 1'b0, 21'h0A0C00);
    chk_pc(21'h0A0C00);
    rv = {16'h0000, fw};
    @(posedge core_clk);
    #1 cmp("instr_reg", rv, {15'h0, exec_valid, ir});
    dec.issue(4'h1, 1'b1, 21'h03F000);
    chk_pc(21'h03F000);
    rd(`PRSU_OFS_STACK_PTR, 8'h01, "ptr_call");
    rd(`PRSU_OFS_TOP_LOW, 8'h02, "top_low");
    rd(`PRSU_OFS_TOP_HIGH, 8'h0C, "top_high");
    rd(`PRSU_OFS_TOP_UPPER, 8'h0A, "top_upper");
    rd(`PRSU_OFS_HIGH_LATCH, 8'h12, "high_latch");
    rd(`PRSU_OFS_UPPER_LATCH, 8'h05, "upper_latch");
    apb(1'b0, `PRSU_OFS_CNT_LOW, 32'h00000000);
    rd(`PRSU_OFS_HIGH_LATCH, 8'hF0, "high_copy");
    rd(`PRSU_OFS_UPPER_LATCH, 8'h03, "upper_copy");
    $display("test call done");
    apb(1'b1, `PRSU_OFS_TOP_LOW, 32'h00000040);
    apb(1'b1, `PRSU_OFS_TOP_HIGH, 32'h00000022);
    apb(1'b1, `PRSU_OFS_TOP_UPPER, 32'h00000001);
    shadow(8'h00, 8'h00, 8'h00);
    dec.issue(4'h4, 1'b1, 21'h000000);
    chk_pc(21'h012240);
    cmp("restore", 32'h01A1B2C3, {7'h0, rs, r_st, r_wk, r_bk});
    rd(`PRSU_OFS_STACK_PTR, 8'h00, "ptr_ret");
    shadow(8'hD4, 8'hE5, 8'hF6);
    dec.issue(4'h3, 1'b0, 21'h000008);
    chk_pc(21'h000008);
    shadow(8'h00, 8'h00, 8'h00);
    dec.issue(4'h6, 1'b1, 21'h000000);
    #1;
    cmp("restore_int", 32'h01D4E5F6, {7'h0, rs, r_st, r_wk, r_bk});
    $display("test return done");
    dec.issue(4'h5, 1'b0, 21'h000000);
    chk_pc(21'h000000);
    cmp("no_reset", 32'h0, {31'h0, dev_rst});
    rd(`PRSU_OFS_STACK_PTR, 8'h40, "ptr_unf");
    apb(1'b1, `PRSU_OFS_STACK_PTR, 32'h000000FF);
    rd(`PRSU_OFS_STACK_PTR, 8'h5F, "ptr_ones");
    apb(1'b1, `PRSU_OFS_STACK_PTR, 32'h00000000);
    rd(`PRSU_OFS_STACK_PTR, 8'h00, "ptr_clear");
    for (i = 0; i < 31; i++) dec.issue(4'h7, 1'b0, 21'h000000);
    rd(`PRSU_OFS_STACK_PTR, 8'h9F, "ptr_full");
    apb(1'b1, `PRSU_OFS_TOP_LOW, 32'h00000055);
    dec.issue(4'h7, 1'b0, 21'h000000);
    rd(`PRSU_OFS_STACK_PTR, 8'h9F, "ptr_hold");
    rd(`PRSU_OFS_TOP_LOW, 8'h55, "entry31_kept");
    dec.issue(4'h8, 1'b0, 21'h000000);
    rd(`PRSU_OFS_STACK_PTR, 8'h9E, "ptr_pop");
    $display("test full done");
    apb(1'b1, `PRSU_OFS_STACK_PTR, 32'h0000001E);
    @(posedge core_clk);
    fault_en <= 1'b1;
    dec.issue(4'h2, 1'b0, 21'h000100);
    chk_pc(21'h000000);
    cmp("ovf_reset", 32'h1, {31'h0, dev_rst});
    rd(`PRSU_OFS_STACK_PTR, 8'h80, "ptr_ovf");
    dec.issue(4'h4, 1'b0, 21'h000000);
    chk_pc(21'h000000);
    cmp("unf_reset", 32'h1, {31'h0, dev_rst});
    rd(`PRSU_OFS_STACK_PTR, 8'hC0, "ptr_unf_rst");
    $display("test fault reset done");
    close_out();
  end
endmodule // testbench
bind prsu_core prsu_asserts chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .op_valid(op_valid), .op_code(op_code), .op_fast(op_fast), .op_target(op_target),
  .stack_fault_reset_enable(stack_fault_reset_enable), .program_counter(program_counter),
  .phase(phase), .exec_valid(exec_valid), .device_reset_req(device_reset_req),
  .restore_strobe(restore_strobe));
`default_nettype wire
